// ==== core/ambs_slave.sv ====
// slave end of the asynchronous multiplexed address/data bus
`timescale 1ns/1ps
`include "ambs_defs.svh"

// Functional notes
// - transfer lasts while sync stays asserted
// - data-in under sync is read; reply
// - data-in without sync requests vector
// - deskew after data-out before latching data
// - reply to data-out to finish write
// - byte write touches only addressed byte
// - reply only after data driven or taken
// - request line when enable and request set
// - requesting device blocks acknowledge, drives vector
// - drop request, assert reply with vector
// - idle device passes acknowledge downstream
// - same lines carry address then data
module ambs_slave #(
  parameter logic [15:0] ADDR_BASE = `AMBS_ADDR_BASE,
  parameter logic [15:0] ADDR_MASK = `AMBS_ADDR_MASK,
  parameter logic        BANK7_SEL = 1'b1,
  parameter logic [15:0] VECTOR    = `AMBS_VECTOR,
  parameter int          DESKEW_NS = `AMBS_DESKEW_NS
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_sync_n,
  input  wire logic                   i_din_n,
  input  wire logic                   i_dout_n,
  input  wire logic                   i_wtbt_n,
  input  wire logic                   i_bank7_n,
  input  wire logic                   i_iak_in_n,
  input  wire logic [`AMBS_DAL_W-1:0] i_dal_n,
  output logic      [`AMBS_DAL_W-1:0] o_dal_n,
  output logic                        o_dal_oe_n,
  output logic                        o_rply_n,
  output logic                        o_irq_n,
  output logic                        o_iak_out_n,
  output logic      [`AMBS_DAL_W-1:0] o_addr,
  output logic                        o_bank7,
  output logic                        o_rd_req,
  input  wire logic                   i_rd_valid,
  input  wire logic [`AMBS_DAL_W-1:0] i_rd_data,
  output logic                        o_wr_req,
  output logic      [`AMBS_DAL_W-1:0] o_wr_data,
  output logic      [1:0]             o_wr_be,
  input  wire logic                   i_irq_set,
  input  wire logic                   i_irq_enable,
  output logic                        o_vec_done
);

  localparam int DESKEW_CYC =
    (DESKEW_NS + `AMBS_CLK_PERIOD_NS - 1) / `AMBS_CLK_PERIOD_NS;

  if (DESKEW_CYC < 1 || DESKEW_CYC > (1 << `AMBS_CNT_W) - 1) begin : g_chk
    $error("deskew count does not fit the counter");
  end

  // ==========================================
  // byte enable decode
  function automatic logic [1:0] be_of(input logic byte_op,
                                       input logic a0);
    if (!byte_op)
      be_of = `AMBS_BE_WORD;
    else if (a0)
      be_of = `AMBS_BE_HI;
    else
      be_of = `AMBS_BE_LO;
  endfunction

  // ==========================================
  // pin synchronisers
  logic [`AMBS_PIN_W-1:0] pins_s;
  logic [`AMBS_DAL_W-1:0] dal_s;
  logic                   sync_s;
  logic                   din_s;
  logic                   dout_s;
  logic                   wtbt_s;
  logic                   bs7_s;
  logic                   iaki_s;

  ambs_sync #(
    .W       (`AMBS_PIN_W),
    .RST_VAL (`AMBS_PIN_IDLE)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_d       ({i_iak_in_n, i_bank7_n, i_wtbt_n, i_dout_n, i_din_n,
                 i_sync_n, i_dal_n}),
    .o_q       (pins_s)
  );

  assign dal_s  = ~pins_s[`AMBS_DAL_W-1:0];
  assign sync_s = ~pins_s[`AMBS_DAL_W];
  assign din_s  = ~pins_s[`AMBS_DAL_W+1];
  assign dout_s = ~pins_s[`AMBS_DAL_W+2];
  assign wtbt_s = ~pins_s[`AMBS_DAL_W+3];
  assign bs7_s  = ~pins_s[`AMBS_DAL_W+4];
  assign iaki_s = ~pins_s[`AMBS_DAL_W+5];

  // ==========================================
  // sequencer state
  ambs_pkg::ambs_state_e  state_reg;
  ambs_pkg::ambs_state_e  state_next;
  logic [`AMBS_DAL_W-1:0] addr_reg;
  logic [`AMBS_DAL_W-1:0] addr_next;
  logic                   bank7_reg;
  logic                   bank7_next;
  logic                   wr_cyc_reg;
  logic                   wr_cyc_next;
  logic [`AMBS_CNT_W-1:0] cnt_reg;
  logic [`AMBS_CNT_W-1:0] cnt_next;
  logic [`AMBS_DAL_W-1:0] dal_out_reg;
  logic [`AMBS_DAL_W-1:0] dal_out_next;
  logic                   dal_oe_reg;
  logic                   dal_oe_next;
  logic                   rply_reg;
  logic                   rply_next;
  logic                   rd_req_reg;
  logic                   rd_req_next;
  logic                   wr_req_reg;
  logic                   wr_req_next;
  logic [`AMBS_DAL_W-1:0] wr_data_reg;
  logic [`AMBS_DAL_W-1:0] wr_data_next;
  logic [1:0]             wr_be_reg;
  logic [1:0]             wr_be_next;
  logic                   irq_req_reg;
  logic                   irq_req_next;
  logic                   irq_reg;
  logic                   irq_next;
  logic                   ia_seen_reg;
  logic                   ia_seen_next;
  logic                   ia_pass_reg;
  logic                   ia_pass_next;
  logic                   iako_reg;
  logic                   iako_next;
  logic                   vec_done_reg;
  logic                   vec_done_next;
  logic                   req_act;
  logic                   in_vec;
  logic                   hit;

  assign req_act = irq_req_reg & i_irq_enable;
  assign in_vec  = (state_reg == ambs_pkg::AMBS_VEC_DRIVE) ||
                   (state_reg == ambs_pkg::AMBS_VEC_REPLY);
  assign hit     = ((dal_s & ADDR_MASK) == ADDR_BASE) &&
                   (bs7_s == BANK7_SEL);

  always_comb begin
    state_next    = state_reg;
    addr_next     = addr_reg;
    bank7_next    = bank7_reg;
    wr_cyc_next   = wr_cyc_reg;
    cnt_next      = cnt_reg;
    dal_out_next  = dal_out_reg;
    dal_oe_next   = dal_oe_reg;
    rply_next     = rply_reg;
    rd_req_next   = 1'b0;
    wr_req_next   = 1'b0;
    wr_data_next  = wr_data_reg;
    wr_be_next    = wr_be_reg;
    vec_done_next = 1'b0;
    ia_seen_next  = ia_seen_reg & iaki_s;
    ia_pass_next  = ia_pass_reg & iaki_s;
    irq_req_next  = irq_req_reg;
    case (state_reg)
      ambs_pkg::AMBS_IDLE: begin
        if (sync_s) begin
          // address and flags taken at sync edge
          addr_next   = dal_s;
          bank7_next  = bs7_s;
          wr_cyc_next = wtbt_s;
          state_next  = hit ? ambs_pkg::AMBS_SELECTED
                            : ambs_pkg::AMBS_UNSEL;
        end else if (iaki_s && !ia_seen_reg) begin
          ia_seen_next = 1'b1;
          if (req_act) begin
            // grant: block acknowledge, put vector out
            dal_out_next = VECTOR;
            dal_oe_next  = 1'b1;
            state_next   = ambs_pkg::AMBS_VEC_DRIVE;
          end else begin
            ia_pass_next = 1'b1;
          end
        end
      end
      ambs_pkg::AMBS_UNSEL: begin
        if (!sync_s)
          state_next = ambs_pkg::AMBS_IDLE;
      end
      ambs_pkg::AMBS_SELECTED: begin
        if (!sync_s) begin
          state_next = ambs_pkg::AMBS_IDLE;
        end else if (din_s) begin
          rd_req_next = 1'b1;
          state_next  = ambs_pkg::AMBS_RD_WAIT;
        end else if (dout_s) begin
          cnt_next   = `AMBS_CNT_W'(DESKEW_CYC - 1);
          state_next = ambs_pkg::AMBS_WR_DESKEW;
        end
      end
      ambs_pkg::AMBS_RD_WAIT: begin
        if (!din_s) begin
          state_next = sync_s ? ambs_pkg::AMBS_SELECTED
                              : ambs_pkg::AMBS_IDLE;
        end else if (i_rd_valid) begin
          dal_out_next = i_rd_data;
          dal_oe_next  = 1'b1;
          state_next   = ambs_pkg::AMBS_RD_DRIVE;
        end
      end
      ambs_pkg::AMBS_RD_DRIVE: begin
        // data stands a cycle before reply
        rply_next  = 1'b1;
        state_next = ambs_pkg::AMBS_RD_REPLY;
      end
      ambs_pkg::AMBS_RD_REPLY: begin
        if (!din_s) begin
          rply_next   = 1'b0;
          dal_oe_next = 1'b0;
          state_next  = sync_s ? ambs_pkg::AMBS_SELECTED
                               : ambs_pkg::AMBS_IDLE;
        end
      end
      ambs_pkg::AMBS_WR_DESKEW: begin
        if (!dout_s) begin
          state_next = sync_s ? ambs_pkg::AMBS_SELECTED
                              : ambs_pkg::AMBS_IDLE;
        end else if (cnt_reg != '0) begin
          cnt_next = cnt_reg - `AMBS_CNT_W'(1);
        end else begin
          wr_data_next = dal_s;
          wr_be_next   = be_of(wtbt_s,
                               addr_reg[`AMBS_BYTE_SEL_BIT]);
          wr_req_next  = 1'b1;
          rply_next    = 1'b1;
          state_next   = ambs_pkg::AMBS_WR_REPLY;
        end
      end
      ambs_pkg::AMBS_WR_REPLY: begin
        if (!dout_s) begin
          rply_next  = 1'b0;
          state_next = sync_s ? ambs_pkg::AMBS_SELECTED
                              : ambs_pkg::AMBS_IDLE;
        end
      end
      ambs_pkg::AMBS_VEC_DRIVE: begin
        if (din_s) begin
          rply_next  = 1'b1;
          state_next = ambs_pkg::AMBS_VEC_REPLY;
        end else if (!iaki_s) begin
          dal_oe_next = 1'b0;
          state_next  = ambs_pkg::AMBS_IDLE;
        end
      end
      ambs_pkg::AMBS_VEC_REPLY: begin
        if (!din_s) begin
          rply_next     = 1'b0;
          dal_oe_next   = 1'b0;
          vec_done_next = 1'b1;
          state_next    = ambs_pkg::AMBS_IDLE;
        end
      end
      default: begin
        state_next = ambs_pkg::AMBS_IDLE;
      end
    endcase
    // new request wins over clear by a served vector
    if (i_irq_set)
      irq_req_next = 1'b1;
    else if (vec_done_next)
      irq_req_next = 1'b0;
    irq_next  = req_act && !in_vec &&
                (state_next != ambs_pkg::AMBS_VEC_DRIVE);
    iako_next = iaki_s && ia_pass_next;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg    <= ambs_pkg::AMBS_IDLE;
      addr_reg     <= '0;
      bank7_reg    <= 1'b0;
      wr_cyc_reg   <= 1'b0;
      cnt_reg      <= '0;
      dal_out_reg  <= '0;
      dal_oe_reg   <= 1'b0;
      rply_reg     <= 1'b0;
      rd_req_reg   <= 1'b0;
      wr_req_reg   <= 1'b0;
      wr_data_reg  <= '0;
      wr_be_reg    <= '0;
      irq_req_reg  <= 1'b0;
      irq_reg      <= 1'b0;
      ia_seen_reg  <= 1'b0;
      ia_pass_reg  <= 1'b0;
      iako_reg     <= 1'b0;
      vec_done_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      addr_reg     <= addr_next;
      bank7_reg    <= bank7_next;
      wr_cyc_reg   <= wr_cyc_next;
      cnt_reg      <= cnt_next;
      dal_out_reg  <= dal_out_next;
      dal_oe_reg   <= dal_oe_next;
      rply_reg     <= rply_next;
      rd_req_reg   <= rd_req_next;
      wr_req_reg   <= wr_req_next;
      wr_data_reg  <= wr_data_next;
      wr_be_reg    <= wr_be_next;
      irq_req_reg  <= irq_req_next;
      irq_reg      <= irq_next;
      ia_seen_reg  <= ia_seen_next;
      ia_pass_reg  <= ia_pass_next;
      iako_reg     <= iako_next;
      vec_done_reg <= vec_done_next;
    end
  end

  // ==========================================
  // outputs, bus side active low
  assign o_dal_n     = ~dal_out_reg;
  assign o_dal_oe_n  = ~dal_oe_reg;
  assign o_rply_n    = ~rply_reg;
  assign o_irq_n     = ~irq_reg;
  assign o_iak_out_n = ~iako_reg;
  assign o_addr      = addr_reg;
  assign o_bank7     = bank7_reg;
  assign o_rd_req    = rd_req_reg;
  assign o_wr_req    = wr_req_reg;
  assign o_wr_data   = wr_data_reg;
  assign o_wr_be     = wr_be_reg;
  assign o_vec_done  = vec_done_reg;

  // ==========================================
  // assertions
  sequence s_data_out;
    dal_oe_reg && !rply_reg;
  endsequence

  sequence s_reply_on;
    rply_reg;
  endsequence

  a_reply_after_data: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    $rose(rply_reg) && !wr_req_reg |-> $past(dal_oe_reg))
    else $error("reply raised before data was driven");

  a_read_reply_seq: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg == ambs_pkg::AMBS_RD_DRIVE |-> s_data_out ##1 s_reply_on)
    else $error("read reply did not follow driven data");

  a_reply_release: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    rply_reg && !din_s && !dout_s |=> !rply_reg)
    else $error("reply held after strobe removed");

  a_deskew_wait: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    $rose(wr_req_reg) |-> $past(dout_s, DESKEW_CYC))
    else $error("write data latched before deskew ended");

  a_write_reply: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    wr_req_reg |-> rply_reg && !dal_oe_reg)
    else $error("write taken without reply");

  a_byte_lane: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    wr_req_reg && wr_be_reg != `AMBS_BE_WORD |->
      wr_be_reg == (addr_reg[`AMBS_BYTE_SEL_BIT] ? `AMBS_BE_HI
                                                 : `AMBS_BE_LO))
    else $error("byte write on wrong lane");

  a_irq_source: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    irq_reg |-> $past(irq_req_reg) && $past(i_irq_enable))
    else $error("request line without enable and request");

  a_vec_block: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    in_vec |-> !iako_reg && dal_oe_reg && dal_out_reg == VECTOR)
    else $error("acknowledge leaked during vector");

  a_vec_irq_drop: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg == ambs_pkg::AMBS_VEC_REPLY |-> !irq_reg && rply_reg)
    else $error("request line high while vector replied");

  a_ack_pass: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    iaki_s && (ia_pass_reg || (state_reg == ambs_pkg::AMBS_IDLE &&
      !sync_s && !ia_seen_reg && !req_act)) |=> iako_reg)
    else $error("acknowledge not passed on");

  a_addr_latched: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg != ambs_pkg::AMBS_IDLE && !in_vec && sync_s |=>
      $stable(addr_reg) && $stable(wr_cyc_reg))
    else $error("selection changed during transfer");

  a_sync_end: assert property (
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    !sync_s && !din_s && !dout_s && !in_vec |=>
      state_reg == ambs_pkg::AMBS_IDLE)
    else $error("transfer kept after sync negated");

endmodule

// ==== core/ambs_defs.svh ====
// constants shared by the multiplexed bus slave
`ifndef AMBS_DEFS_SVH
`define AMBS_DEFS_SVH

// ==========================================
// bus widths
`define AMBS_DAL_W          16
`define AMBS_CTL_W          6
`define AMBS_PIN_W          22
`define AMBS_PIN_IDLE       22'h3FFFFF

// ==========================================
// timing
`define AMBS_CLK_PERIOD_NS  5
`define AMBS_DESKEW_NS      100
`define AMBS_CNT_W          8

// ==========================================
// byte lanes
`define AMBS_BYTE_SEL_BIT   0
`define AMBS_BE_LO          2'h1
`define AMBS_BE_HI          2'h2
`define AMBS_BE_WORD        2'h3

// ==========================================
// default decode and vector
`define AMBS_ADDR_BASE      16'h1F40
`define AMBS_ADDR_MASK      16'hFFF0
`define AMBS_VECTOR         16'h0060

`endif

// ==== core/ambs_pkg.sv ====
// types of the multiplexed bus slave
package ambs_pkg;

  // ==========================================
  // transfer sequencer states
  typedef enum logic [3:0] {
    AMBS_IDLE,
    AMBS_SELECTED,
    AMBS_UNSEL,
    AMBS_RD_WAIT,
    AMBS_RD_DRIVE,
    AMBS_RD_REPLY,
    AMBS_WR_DESKEW,
    AMBS_WR_REPLY,
    AMBS_VEC_DRIVE,
    AMBS_VEC_REPLY
  } ambs_state_e;

endpackage

// ==== core/ambs_sync.sv ====
// two-flop synchroniser bank for bus pins
`timescale 1ns/1ps
module ambs_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = i_d;
    q_next    = meta_reg;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule

// ==== tb/ambs_master_model.sv ====
// bus master model for the multiplexed bus slave
`timescale 1ns/1ps
module ambs_master_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_dal_n,
  input  wire logic        i_dal_oe_n,
  input  wire logic        i_rply_n,
  output logic             o_sync_n,
  output logic             o_din_n,
  output logic             o_dout_n,
  output logic             o_wtbt_n,
  output logic             o_bank7_n,
  output logic             o_iak_n,
  output logic      [15:0] o_dal_n
);
  logic [15:0] drv_n;
  logic        drv_en;
  int          wait_cyc;
  // ==========================================
  // pulled-up lines: released bits float high
  assign o_dal_n = (drv_en ? drv_n : 16'hFFFF)
                 & (i_dal_oe_n ? 16'hFFFF : i_dal_n);
  initial begin
    {o_sync_n, o_din_n, o_dout_n, o_wtbt_n, o_bank7_n, o_iak_n} = 6'h3F;
    drv_n = 16'hFFFF;
    drv_en = 1'b0;
  end
  // ==========================================
  // handshake helpers
  task automatic await_rply(input logic lvl, output logic ok);
    ok = 1'b0;
    wait_cyc = 0;
    while (!ok && wait_cyc < 100) begin
      @(posedge i_clk_sys);
      wait_cyc++;
      if (i_rply_n === lvl) ok = 1'b1;
    end
  endtask
  task automatic address(input logic [15:0] a, input logic b7,
                         input logic wt);
    @(posedge i_clk_sys);
    drv_n <= ~a;
    drv_en <= 1'b1;
    o_bank7_n <= ~b7;
    o_wtbt_n <= ~wt;
    @(posedge i_clk_sys);
    o_sync_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    drv_en <= 1'b0;
    o_bank7_n <= 1'b1;
  endtask
  task automatic read_word(output logic [15:0] d, output logic ok);
    logic ok2;
    @(posedge i_clk_sys);
    o_din_n <= 1'b0;
    await_rply(1'b0, ok);
    d = ~o_dal_n;
    o_din_n <= 1'b1;
    await_rply(1'b1, ok2);
    ok = ok & ok2;
  endtask
  task automatic write_word(input logic [15:0] d, input logic byt,
                            output logic ok, output int dly);
    logic ok2;
    @(posedge i_clk_sys);
    drv_n <= ~d;
    drv_en <= 1'b1;
    o_wtbt_n <= ~byt;
    @(posedge i_clk_sys);
    o_dout_n <= 1'b0;
    await_rply(1'b0, ok);
    dly = wait_cyc;
    o_dout_n <= 1'b1;
    await_rply(1'b1, ok2);
    drv_en <= 1'b0;
    ok = ok & ok2;
  endtask
  task automatic end_cycle();
    @(posedge i_clk_sys);
    o_sync_n <= 1'b1;
    o_wtbt_n <= 1'b1;
    drv_en <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic vector(output logic [15:0] v, output logic ok);
    logic ok2;
    @(posedge i_clk_sys);
    o_iak_n <= 1'b0;
    o_din_n <= 1'b0;
    await_rply(1'b0, ok);
    v = ~o_dal_n;
    o_din_n <= 1'b1;
    o_iak_n <= 1'b1;
    await_rply(1'b1, ok2);
    ok = ok & ok2;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule

// ==== tb/tb.sv ====
// testbench of the multiplexed bus slave
`timescale 1ns/1ps
`include "ambs_defs.svh"
module tb;
  logic        i_clk_sys, i_arst_n, i_rd_valid, i_irq_set, i_irq_enable;
  logic        sync_n, din_n, dout_n, wtbt_n, bank7_n, iak_n;
  logic [15:0] dal_in_n, o_dal_n, i_rd_data, o_addr, o_wr_data, rd_word;
  logic        o_dal_oe_n, o_rply_n, o_irq_n, o_iak_out_n, o_bank7;
  logic        o_rd_req, o_wr_req, o_vec_done;
  logic [1:0]  o_wr_be, wr_be;
  logic [15:0] wr_data;
  int          err_count, comparisons, rd_cnt, wr_cnt, vec_cnt, iak_cnt;
  localparam logic [15:0] BASE = `AMBS_ADDR_BASE;
  // ==========================================
  // clock, design and master
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  ambs_slave #(.DESKEW_NS(25)) dut_u (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_sync_n(sync_n),
    .i_din_n(din_n), .i_dout_n(dout_n), .i_wtbt_n(wtbt_n),
    .i_bank7_n(bank7_n), .i_iak_in_n(iak_n), .i_dal_n(dal_in_n),
    .o_dal_n(o_dal_n), .o_dal_oe_n(o_dal_oe_n), .o_rply_n(o_rply_n),
    .o_irq_n(o_irq_n), .o_iak_out_n(o_iak_out_n), .o_addr(o_addr),
    .o_bank7(o_bank7), .o_rd_req(o_rd_req), .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data), .o_wr_req(o_wr_req), .o_wr_data(o_wr_data),
    .o_wr_be(o_wr_be), .i_irq_set(i_irq_set),
    .i_irq_enable(i_irq_enable), .o_vec_done(o_vec_done));
  ambs_master_model m_u (
    .i_clk_sys(i_clk_sys), .i_dal_n(o_dal_n), .i_dal_oe_n(o_dal_oe_n),
    .i_rply_n(o_rply_n), .o_sync_n(sync_n), .o_din_n(din_n),
    .o_dout_n(dout_n), .o_wtbt_n(wtbt_n), .o_bank7_n(bank7_n),
    .o_iak_n(iak_n), .o_dal_n(dal_in_n));
  // ==========================================
  // user side and event counters
  always @(posedge i_clk_sys) begin
    i_rd_valid <= o_rd_req;
    i_rd_data <= rd_word;
    if (o_rd_req === 1'b1) rd_cnt++;
    if (o_vec_done === 1'b1) vec_cnt++;
    if (o_iak_out_n === 1'b0) iak_cnt++;
    if (o_wr_req === 1'b1) begin
      wr_cnt++;
      wr_data = o_wr_data;
      wr_be = o_wr_be;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_read();
    logic [15:0] d;
    logic        ok;
    int          n;
    rd_word = 16'hA55A;
    n = rd_cnt;
    m_u.address(BASE, 1'b1, 1'b0);
    m_u.read_word(d, ok);
    chk("read ok", 16'h1, {15'h0, ok});
    chk("read data", 16'hA55A, d);
    chk("read req", 16'(n + 1), 16'(rd_cnt));
    chk("addr", BASE, o_addr);
    chk("bank7", 16'h1, {15'h0, o_bank7});
    chk("rply off", 16'h1, {15'h0, o_rply_n});
    chk("oe off", 16'h1, {15'h0, o_dal_oe_n});
    m_u.end_cycle();
  endtask
  task automatic t_write();
    logic [15:0] a [2] = '{BASE + 16'h2, BASE + 16'h4};
    logic        byt [2] = '{1'b0, 1'b1};
    logic [1:0]  be [2] = '{`AMBS_BE_WORD, `AMBS_BE_LO};
    logic        ok;
    int          dly;
    for (int i = 0; i < 2; i++) begin
      m_u.address(a[i], 1'b1, 1'b1);
      m_u.write_word(16'h3C96, byt[i], ok, dly);
      chk("write ok", 16'h1, {15'h0, ok});
      chk("deskew", 16'h1, {15'h0, dly >= 7});
      chk("wr data", 16'h3C96, wr_data);
      chk("wr be", {14'h0, be[i]}, {14'h0, wr_be});
      m_u.end_cycle();
    end
  endtask
  task automatic t_rmw();
    logic [15:0] d;
    logic        ok;
    int          dly, n;
    rd_word = 16'h0F0F;
    m_u.address(BASE + 16'h1, 1'b1, 1'b0);
    m_u.read_word(d, ok);
    chk("rmw read", 16'h0F0F, d);
    n = wr_cnt;
    m_u.write_word(16'h1200, 1'b1, ok, dly);
    chk("rmw write", 16'h1, {15'h0, ok});
    chk("rmw count", 16'(n + 1), 16'(wr_cnt));
    chk("rmw hi", 16'h12, {8'h0, wr_data[15:8]});
    chk("rmw be", {14'h0, `AMBS_BE_HI}, {14'h0, wr_be});
    chk("rmw addr", BASE + 16'h1, o_addr);
    m_u.end_cycle();
  endtask
  task automatic t_miss();
    logic [15:0] a [2] = '{BASE, BASE + 16'h1000};
    logic        b7 [2] = '{1'b0, 1'b1};
    logic [15:0] d;
    logic        ok;
    int          n;
    for (int i = 0; i < 2; i++) begin
      n = rd_cnt;
      m_u.address(a[i], b7[i], 1'b0);
      m_u.read_word(d, ok);
      chk("miss quiet", 16'h0, {15'h0, ok});
      chk("miss req", 16'(n), 16'(rd_cnt));
      m_u.end_cycle();
    end
  endtask
  task automatic t_irq();
    logic [15:0] v;
    logic        ok;
    int          n;
    @(posedge i_clk_sys);
    i_irq_set <= 1'b1;
    @(posedge i_clk_sys);
    i_irq_set <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk("irq masked", 16'h1, {15'h0, o_irq_n});
    i_irq_enable <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk("irq on", 16'h0, {15'h0, o_irq_n});
    n = iak_cnt;
    vec_cnt = 0;
    m_u.vector(v, ok);
    chk("vec ok", 16'h1, {15'h0, ok});
    chk("vector", `AMBS_VECTOR, v);
    chk("iak held", 16'(n), 16'(iak_cnt));
    chk("irq off", 16'h1, {15'h0, o_irq_n});
    chk("vec done", 16'h1, 16'(vec_cnt));
    m_u.vector(v, ok);
    chk("no vector", 16'h0, {15'h0, ok});
    chk("iak passed", 16'h1, {15'h0, iak_cnt > n});
    chk("iak idle", 16'h1, {15'h0, o_iak_out_n});
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    {i_arst_n, i_rd_valid, i_irq_set, i_irq_enable} = 4'h0;
    i_rd_data = 16'h0;
    rd_word = 16'h0;
    repeat (2) @(posedge i_clk_sys);
    chk("reset rply", 16'h1, {15'h0, o_rply_n});
    chk("reset oe", 16'h1, {15'h0, o_dal_oe_n});
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    t_read();
    t_write();
    t_rmw();
    t_miss();
    t_irq();
    close_out();
  end
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule
